// ===== logic/touch_drive_gen.v
`timescale 1ns/10ps
`default_nettype none
`include "touch_sense_defines.vh"
module touch_drive_gen (
	input wire clock_in,
	input wire arst_n_in,
	input wire ce_in,
	input wire run_in,
	input wire [1:0] clk_sel_in,
	input wire [7:0] freq_div_in,
	input wire spread_in,
	input wire phase_in,
	input wire hop_in,
	output wire tick_out,
	output reg drive_out
);
	reg [2:0] pre;
	reg [8:0] half_cnt;
	reg [7:0] lfsr;
	reg [1:0] hop_idx;
	reg phase_hold;
	wire [2:0] mask;
	wire [8:0] half_len;
	// 00 undivided, 01 /2, 10 /4, 11 /8
	assign mask = (clk_sel_in == 2'h0) ? 3'h0 : (clk_sel_in == 2'h1) ? 3'h1 :
		(clk_sel_in == 2'h2) ? 3'h3 : 3'h7; // [R1]
	assign tick_out = ce_in && ((pre & mask) == mask);
	// spread adds a small random step, hopping moves between three base rates
	assign half_len = {1'b0, freq_div_in} + (spread_in ? {7'h00, lfsr[1:0]} : 9'h000) +
		(hop_in ? {5'h00, hop_idx, 2'h0} : 9'h000); // [R18]
	always @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pre <= 3'h0;
			half_cnt <= 9'h000;
			lfsr <= 8'h01;
			hop_idx <= 2'h0;
			phase_hold <= 1'b0;
			drive_out <= 1'b0;
		end else if (ce_in) begin
			pre <= pre + 3'h1;
			if (!run_in) begin
				half_cnt <= 9'h000;
				drive_out <= 1'b0;
			end else if (tick_out) begin
				lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
				if (phase_hold) begin
					phase_hold <= 1'b0;
				end else if (half_cnt >= half_len) begin
					half_cnt <= 9'h000;
					drive_out <= ~drive_out;
					// random phase shift stretches one half period by a tick
					phase_hold <= phase_in && lfsr[2]; // [R18]
					if (drive_out)
						hop_idx <= (hop_idx == 2'h2) ? 2'h0 : hop_idx + 2'h1;
				end else begin
					half_cnt <= half_cnt + 9'h001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== logic/touch_sense_defines.vh
`ifndef TOUCH_SENSE_DEFINES_VH
`define TOUCH_SENSE_DEFINES_VH
// register byte offsets
`define TS_OFS_CTRL_A 8'h00
`define TS_OFS_CHEN_LO 8'h04
`define TS_OFS_CHEN_HI 8'h08
`define TS_OFS_CHSEL 8'h0C
`define TS_OFS_CHCFG 8'h10
`define TS_OFS_RESULT 8'h14
`define TS_OFS_STATUS 8'h18
`define TS_OFS_CTRL_B 8'h1C
`define TS_OFS_THRESH 8'h20
// touch_control_a fields
`define TS_GO_BIT 0
`define TS_TRIG_SEL_BIT 1
`define TS_SLEEP_EN_BIT 2
`define TS_INIT_BIT 4
`define TS_TXSUP_LSB 6
`define TS_SUPPLY_ON_BIT 8
`define TS_FILTER_BIT 9
`define TS_SUPLVL_BIT 10
`define TS_RANGE_LO_BIT 11
`define TS_CLKSEL_LSB 12
`define TS_KIND0_BIT 14
`define TS_KIND1_BIT 15
`define TS_RANGE_HI_BIT 17
`define TS_CTRL_A_MASK 32'h0002FFC6
`define TS_CTRL_A_RESET 32'h00000000
// control b fields
`define TS_CURRENT_MODE_BIT 0
`define TS_SPREAD_BIT 1
`define TS_PHASE_BIT 2
`define TS_HOP_BIT 3
`define TS_AUTO_JUDGE_BIT 4
// channel settings fields
`define TS_CFG_OFS_LSB 0
`define TS_CFG_DUR_LSB 10
`define TS_CFG_FREQ_LSB 18
// status fields
`define TS_STC_LSB 8
`define TS_XFER_BIT 12
`define TS_SENSOR_COUNT_OVERFLOW_BIT 13
`define TS_UNIT_CLOCK_COUNT_OVERFLOW_BIT 14
`define TS_MUTUAL_BIT 15
// status counter codes
`define TS_STC_IDLE 3'h0
`define TS_STC_SETUP 3'h1
`define TS_STC_SENSE 3'h2
`define TS_STC_READ 3'h3
`define TS_CHANNELS 36
`endif

// ===== logic/touch_sensing_control.v
// Behaviour
// R1 - clock select 13:12 divides peripheral clock by 1, 2, 4 or 8
// R2 - mode field 15:14 picks self/mutual and single/multi scan
// R3 - transmit supply field 7:6: io, vcc, logic, vcc
// R4 - range bits 17 and 11: 80, 40, lowest, 160 microamps
// R5 - bit 8 turns measurement supply on
// R6 - bit 9 controls filter capacitor charging
// R7 - software sets bit 10 below 2.4 V supply
// R8 - go bit starts software measurement and reads busy
// R9 - trigger select picks software bit or event input
// R10 - event input from event link starts a measurement
// R11 - sleep measure runs from events, end cancels sleep
// R12 - automatic judgement ends sleep when nothing touched
// R13 - init bit returns measurement control to idle
// R14 - three requests: setting, result read, measurement end
// R15 - single scan measures one selected channel
// R16 - multi scan walks all enabled channels in turn
// R17 - up to 36 channels, fewer if parameter says so; code applies the limit to multi scan only, single scan takes chan_sel unmasked
// R18 - drive pulses offer spreading, phase shift and hopping
// R19 - per channel offset, drive frequency and duration
// R20 - current mode reads pin current directly
// R21 - status holds counter 10:8 and transfer flag 12
// R22 - status holds overflow flags at 13 and 14
// R23 - software answers each request before next channel
`timescale 1ns/10ps
`default_nettype none
`include "touch_sense_defines.vh"
module touch_sensing_control #(
	parameter CHANNELS = `TS_CHANNELS,
	parameter AUTO_JUDGE = 1
) (
	input wire clock_in,
	input wire arst_n_in,
	input wire ce_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [7:0] paddr_in,
	input wire [31:0] pwdata_in,
	output reg [31:0] prdata_out,
	output reg pready_out,
	output reg pslverr_out,
	input wire event_trigger_in,
	input wire snooze_in,
	input wire sensor_pulse_in,
	input wire [15:0] pin_current_in,
	output reg [5:0] channel_out,
	output reg mutual_out,
	output reg measuring_out,
	output reg sensor_drive_out,
	output reg [9:0] offset_current_out,
	output reg [1:0] transmit_supply_select_out,
	output reg [1:0] current_range_out,
	output reg measure_supply_on_out,
	output reg filter_charge_control_out,
	output reg supply_operating_level_out,
	output reg setting_request_irq_out,
	output reg result_read_irq_out,
	output reg measure_end_irq_out,
	output reg snooze_exit_out
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_SETUP = 4'b0010;
	localparam ST_SENSE = 4'b0100;
	localparam ST_READ = 4'b1000;

	reg [3:0] state;
	reg [3:0] next_state;
	reg [31:0] ctrl_a;
	reg [4:0] ctrl_b;
	reg [35:0] chan_en;
	reg [5:0] chan_sel;
	reg [25:0] chan_cfg;
	reg [15:0] threshold;
	reg [15:0] sense_count;
	reg [15:0] result;
	reg [7:0] dur_ticks;
	reg [15:0] unit_count;
	reg xfer_flag;
	reg sensor_count_overflow;
	reg unit_clock_count_overflow;
	reg touch_seen;
	reg in_sleep_run;
	reg pulse_prev;
	reg [6:0] next_pick;
	reg [31:0] next_prdata;
	wire tick;
	wire drive;
	wire wr_acc;
	wire rd_acc;
	wire init_req;
	wire multi;
	wire sw_start;
	wire ev_start;
	wire start;
	wire start_multi;
	wire result_taken;
	wire cfg_written;
	wire [35:0] en_mask;
	wire [6:0] first_pick;
	wire [6:0] later_pick;
	wire [2:0] status_counter;

	// lowest enabled channel at or above start; bit 6 flags a hit
	function [6:0] find_from;
		input [35:0] en;
		input [6:0] from;
		integer i;
		begin
			find_from = 7'h00;
			for (i = 35; i >= 0; i = i - 1) begin
				if (en[i] && (i >= from))
					find_from = {1'b1, i[5:0]};
			end
		end
	endfunction

	function addr_known;
		input [7:0] a;
		begin
			addr_known = (a == `TS_OFS_CTRL_A) || (a == `TS_OFS_CHEN_LO) ||
				(a == `TS_OFS_CHEN_HI) || (a == `TS_OFS_CHSEL) ||
				(a == `TS_OFS_CHCFG) || (a == `TS_OFS_RESULT) ||
				(a == `TS_OFS_STATUS) || (a == `TS_OFS_CTRL_B) ||
				(a == `TS_OFS_THRESH);
		end
	endfunction

	assign wr_acc = psel_in && penable_in && pready_out && pwrite_in &&
		addr_known(paddr_in);
	assign rd_acc = psel_in && penable_in && pready_out && !pwrite_in;
	assign init_req = wr_acc && (paddr_in == `TS_OFS_CTRL_A) &&
		pwdata_in[`TS_INIT_BIT]; // [R13]
	assign multi = ctrl_a[`TS_KIND0_BIT]; // [R2]
	// channels above the fitted count never take part in a multi scan; single scan uses chan_sel unmasked
	assign en_mask = (CHANNELS >= 36) ? chan_en :
		(chan_en & ((36'h000000001 << CHANNELS) - 36'h000000001)); // [R17]
	assign first_pick = find_from(en_mask, 7'h00);
	assign later_pick = find_from(en_mask, {1'b0, channel_out} + 7'h01);
	assign sw_start = wr_acc && (paddr_in == `TS_OFS_CTRL_A) &&
		pwdata_in[`TS_GO_BIT] && !ctrl_a[`TS_TRIG_SEL_BIT] && !snooze_in; // [R8]
	// while asleep the event only counts if sleep measurement is allowed
	assign ev_start = event_trigger_in && ctrl_a[`TS_TRIG_SEL_BIT] &&
		(!snooze_in || ctrl_a[`TS_SLEEP_EN_BIT]); // [R9] [R10] [R11]
	assign start = (state == ST_IDLE) && (sw_start || ev_start) && !init_req;
	// a go write that also sets the mode must scan in the new mode, not the old one
	assign start_multi = sw_start ? pwdata_in[`TS_KIND0_BIT] : multi; // [R2]
	assign result_taken = rd_acc && (paddr_in == `TS_OFS_RESULT);
	assign cfg_written = wr_acc && (paddr_in == `TS_OFS_CHCFG);
	assign status_counter = (state == ST_SETUP) ? `TS_STC_SETUP : (state == ST_SENSE) ?
		`TS_STC_SENSE : (state == ST_READ) ? `TS_STC_READ : `TS_STC_IDLE;

	touch_drive_gen u_drive (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.run_in(state == ST_SENSE),
		.clk_sel_in(ctrl_a[`TS_CLKSEL_LSB +: 2]),
		.freq_div_in(chan_cfg[`TS_CFG_FREQ_LSB +: 8]),
		.spread_in(ctrl_b[`TS_SPREAD_BIT]),
		.phase_in(ctrl_b[`TS_PHASE_BIT]),
		.hop_in(ctrl_b[`TS_HOP_BIT]),
		.tick_out(tick),
		.drive_out(drive)
	);

	always @* begin
		next_state = state;
		next_pick = 7'h00;
		case (state)
			ST_IDLE: begin
				next_pick = start_multi ? first_pick : {1'b1, chan_sel}; // [R15] [R16]
				if (start && next_pick[6])
					next_state = ST_SETUP;
			end
			ST_SETUP: begin
				if (cfg_written)
					next_state = ST_SENSE; // [R23]
			end
			ST_SENSE: begin
				if (tick && (dur_ticks == 8'h00))
					next_state = ST_READ;
			end
			ST_READ: begin
				next_pick = later_pick;
				if (result_taken)
					next_state = (multi && later_pick[6]) ? ST_SETUP : ST_IDLE; // [R16]
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (init_req)
			next_state = ST_IDLE; // [R13]
	end

	always @* begin
		next_prdata = 32'h00000000;
		case (paddr_in)
			`TS_OFS_CTRL_A: begin
				next_prdata = ctrl_a & `TS_CTRL_A_MASK;
				next_prdata[`TS_GO_BIT] = (state != ST_IDLE); // [R8]
			end
			`TS_OFS_CHEN_LO: next_prdata = chan_en[31:0];
			`TS_OFS_CHEN_HI: next_prdata = {28'h0000000, chan_en[35:32]};
			`TS_OFS_CHSEL: next_prdata = {26'h0000000, chan_sel};
			`TS_OFS_CHCFG: next_prdata = {6'h00, chan_cfg};
			`TS_OFS_RESULT: next_prdata = {10'h000, channel_out, result};
			`TS_OFS_STATUS: begin
				next_prdata[`TS_STC_LSB +: 3] = status_counter; // [R21]
				next_prdata[`TS_XFER_BIT] = xfer_flag; // [R21]
				next_prdata[`TS_SENSOR_COUNT_OVERFLOW_BIT] = sensor_count_overflow; // [R22]
				next_prdata[`TS_UNIT_CLOCK_COUNT_OVERFLOW_BIT] = unit_clock_count_overflow; // [R22]
				next_prdata[`TS_MUTUAL_BIT] = ctrl_a[`TS_KIND1_BIT];
				next_prdata[5:0] = channel_out;
			end
			`TS_OFS_CTRL_B: next_prdata = {27'h0000000, ctrl_b};
			`TS_OFS_THRESH: next_prdata = {16'h0000, threshold};
			default: next_prdata = 32'h00000000;
		endcase
	end

	// bus slave: one wait-free access phase, data captured at setup
	always @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prdata_out <= 32'h00000000;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end else if (ce_in) begin
			pready_out <= psel_in && !penable_in;
			if (psel_in && !penable_in) begin
				prdata_out <= pwrite_in ? 32'h00000000 : next_prdata;
				pslverr_out <= !addr_known(paddr_in);
			end else begin
				pslverr_out <= 1'b0;
			end
		end
	end

	// software registers
	always @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_a <= `TS_CTRL_A_RESET;
			ctrl_b <= 5'h00;
			chan_en <= 36'h000000000;
			chan_sel <= 6'h00;
			chan_cfg <= 26'h0000000;
			threshold <= 16'h0000;
		end else if (ce_in && wr_acc) begin
			case (paddr_in)
				`TS_OFS_CTRL_A: ctrl_a <= pwdata_in & `TS_CTRL_A_MASK;
				`TS_OFS_CHEN_LO: chan_en[31:0] <= pwdata_in;
				`TS_OFS_CHEN_HI: chan_en[35:32] <= pwdata_in[3:0];
				`TS_OFS_CHSEL: chan_sel <= pwdata_in[5:0];
				`TS_OFS_CHCFG: chan_cfg <= pwdata_in[25:0]; // [R19]
				`TS_OFS_CTRL_B: ctrl_b <= pwdata_in[4:0];
				`TS_OFS_THRESH: threshold <= pwdata_in[15:0];
				default: threshold <= threshold;
			endcase
		end
	end

	// measurement sequencer and its counters
	always @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= ST_IDLE;
			channel_out <= 6'h00;
			dur_ticks <= 8'h00;
			sense_count <= 16'h0000;
			unit_count <= 16'h0000;
			result <= 16'h0000;
			xfer_flag <= 1'b0;
			sensor_count_overflow <= 1'b0;
			unit_clock_count_overflow <= 1'b0;
			touch_seen <= 1'b0;
			in_sleep_run <= 1'b0;
			pulse_prev <= 1'b0;
			setting_request_irq_out <= 1'b0;
			result_read_irq_out <= 1'b0;
			measure_end_irq_out <= 1'b0;
			snooze_exit_out <= 1'b0;
		end else if (ce_in) begin
			state <= next_state;
			pulse_prev <= sensor_pulse_in;
			setting_request_irq_out <= 1'b0;
			result_read_irq_out <= 1'b0;
			measure_end_irq_out <= 1'b0;
			snooze_exit_out <= 1'b0;
			// flag writes of one clear; a same-cycle overflow still sets
			if (wr_acc && (paddr_in == `TS_OFS_STATUS)) begin
				if (pwdata_in[`TS_SENSOR_COUNT_OVERFLOW_BIT])
					sensor_count_overflow <= 1'b0;
				if (pwdata_in[`TS_UNIT_CLOCK_COUNT_OVERFLOW_BIT])
					unit_clock_count_overflow <= 1'b0;
			end
			if (result_taken)
				xfer_flag <= 1'b0; // [R21]
			if (init_req) begin
				xfer_flag <= 1'b0; // [R13]
				sensor_count_overflow <= 1'b0;
				unit_clock_count_overflow <= 1'b0;
				in_sleep_run <= 1'b0;
			end else if (state == ST_IDLE) begin
				if (start && next_pick[6]) begin
					channel_out <= next_pick[5:0];
					setting_request_irq_out <= 1'b1; // [R14]
					touch_seen <= 1'b0;
					in_sleep_run <= snooze_in; // [R11]
				end else if (start) begin
					measure_end_irq_out <= 1'b1; // nothing enabled to scan
				end
			end else if (state == ST_SETUP) begin
				if (cfg_written) begin
					dur_ticks <= pwdata_in[`TS_CFG_DUR_LSB +: 8]; // [R19]
					sense_count <= 16'h0000;
					unit_count <= 16'h0000;
				end
			end else if (state == ST_SENSE) begin
				if (sensor_pulse_in && !pulse_prev) begin
					if (sense_count == 16'hFFFF)
						sensor_count_overflow <= 1'b1; // [R22]
					else
						sense_count <= sense_count + 16'h0001;
				end
				if (tick) begin
					unit_count <= unit_count + 16'h0001;
					if (unit_count == 16'hFFFF)
						unit_clock_count_overflow <= 1'b1; // [R22]
					if (dur_ticks == 8'h00) begin
						// current mode bypasses the capacitance counter
						result <= ctrl_b[`TS_CURRENT_MODE_BIT] ? pin_current_in :
							sense_count; // [R20]
						xfer_flag <= 1'b1;
						result_read_irq_out <= 1'b1; // [R14]
					end else begin
						dur_ticks <= dur_ticks - 8'h01;
					end
				end
			end else if (state == ST_READ) begin
				if (result >= threshold)
					touch_seen <= 1'b1;
				if (result_taken && multi && later_pick[6]) begin
					channel_out <= later_pick[5:0]; // [R16]
					setting_request_irq_out <= 1'b1;
				end else if (result_taken) begin
					measure_end_irq_out <= 1'b1; // [R14]
					in_sleep_run <= 1'b0;
					// without judgement every end wakes; with it only quiet scans
					snooze_exit_out <= in_sleep_run && (!(AUTO_JUDGE != 0 &&
						ctrl_b[`TS_AUTO_JUDGE_BIT]) || !(touch_seen ||
						result >= threshold)); // [R11] [R12]
				end
			end
		end
	end

	// pin-facing outputs, registered
	always @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mutual_out <= 1'b0;
			measuring_out <= 1'b0;
			sensor_drive_out <= 1'b0;
			offset_current_out <= 10'h000;
			transmit_supply_select_out <= 2'h0;
			current_range_out <= 2'h0;
			measure_supply_on_out <= 1'b0;
			filter_charge_control_out <= 1'b0;
			supply_operating_level_out <= 1'b0;
		end else if (ce_in) begin
			mutual_out <= ctrl_a[`TS_KIND1_BIT]; // [R2]
			measuring_out <= (next_state == ST_SENSE);
			sensor_drive_out <= drive;
			offset_current_out <= chan_cfg[`TS_CFG_OFS_LSB +: 10]; // [R19]
			transmit_supply_select_out <= ctrl_a[`TS_TXSUP_LSB +: 2]; // [R3]
			// {high,low}: 00 80uA, 01 40uA, 10 lowest, 11 160uA
			current_range_out <= {ctrl_a[`TS_RANGE_HI_BIT],
				ctrl_a[`TS_RANGE_LO_BIT]}; // [R4]
			measure_supply_on_out <= ctrl_a[`TS_SUPPLY_ON_BIT]; // [R5]
			filter_charge_control_out <= ctrl_a[`TS_FILTER_BIT]; // [R6]
			supply_operating_level_out <= ctrl_a[`TS_SUPLVL_BIT]; // [R7]
		end
	end
endmodule
`default_nettype wire

// ===== verification/touch_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module touch_far_side (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic measuring_in,
	input wire logic fire_in,
	input wire logic slow_in,
	output var logic sensor_pulse_out,
	output var logic event_trigger_out,
	output wire logic [15:0] pin_current_out
);
	logic fire_q;
	logic [1:0] phase;
	// current only settles while sensing; a moving value exposes early sampling
	assign pin_current_out = measuring_in ? 16'h1234 : ~16'h1234 ^ {14'h0, phase};
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			fire_q <= 1'b0;
			phase <= 2'h0;
			sensor_pulse_out <= 1'b0;
			event_trigger_out <= 1'b0;
		end else begin
			fire_q <= fire_in;
			event_trigger_out <= fire_in && !fire_q;
			phase <= phase + 2'h1;
			sensor_pulse_out <= measuring_in && (slow_in ? phase[1] : !sensor_pulse_out);
		end
	end
endmodule
`default_nettype wire

// ===== verification/touch_sense_props.sv
`timescale 1ns/10ps
`default_nettype none
module touch_sense_props (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic event_trigger_in,
	input wire logic snooze_in,
	input wire logic mutual_out,
	input wire logic [1:0] transmit_supply_select_out,
	input wire logic [1:0] current_range_out,
	input wire logic measure_supply_on_out,
	input wire logic filter_charge_control_out,
	input wire logic setting_request_irq_out,
	input wire logic result_read_irq_out,
	input wire logic measure_end_irq_out,
	input wire logic snooze_exit_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);
	logic acc, wr_a, rd_res, start, trig_sel, sleep_en, busy, wait_rd;
	assign acc = psel_in && penable_in && pready_out;
	assign wr_a = acc && pwrite_in && paddr_in == 8'h00;
	assign rd_res = acc && !pwrite_in && paddr_in == 8'h14;
	// start qualifier uses the trigger select held before the write
	assign start = !busy && ((wr_a && pwdata_in[0] && !trig_sel && !snooze_in)
		|| (event_trigger_in && trig_sel && (!snooze_in || sleep_en)));
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			trig_sel <= 1'b0;
			sleep_en <= 1'b0;
			busy <= 1'b0;
			wait_rd <= 1'b0;
		end else begin
			if (wr_a) begin
				trig_sel <= pwdata_in[1];
				sleep_en <= pwdata_in[2];
			end
			if (start)
				busy <= 1'b1;
			else if (measure_end_irq_out || (wr_a && pwdata_in[4]))
				busy <= 1'b0;
			if (result_read_irq_out)
				wait_rd <= 1'b1;
			else if (rd_res || (wr_a && pwdata_in[4]))
				wait_rd <= 1'b0;
		end
	end
	a_tx_supply: assert property (wr_a |-> ##2
		transmit_supply_select_out == $past(pwdata_in[7:6], 2)) else $error("supply select lag");
	a_range_pair: assert property (wr_a |-> ##2
		current_range_out == {$past(pwdata_in[17], 2), $past(pwdata_in[11], 2)})
		else $error("current range lag");
	a_supply_on: assert property (wr_a |=> ##1
		measure_supply_on_out == $past(pwdata_in[8], 2)) else $error("supply enable lag");
	a_filter_bit: assert property (wr_a |-> ##2
		filter_charge_control_out == $past(pwdata_in[9], 2)) else $error("filter bit lag");
	a_mode_mutual: assert property (wr_a |-> ##2 mutual_out == $past(pwdata_in[15], 2))
		else $error("mutual mode lag");
	a_ready_once: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
		else $error("ready not single access cycle");
	a_unmapped_err: assert property (psel_in && !penable_in && paddr_in > 8'h20
		|=> pslverr_out && pready_out) else $error("unmapped access not refused");
	a_start_request: assert property (start |=> setting_request_irq_out)
		else $error("start without setting request");
	a_after_read: assert property (rd_res && wait_rd |=>
		setting_request_irq_out != measure_end_irq_out) else $error("no request after read");
	a_irq_pulse: assert property (setting_request_irq_out |=> !setting_request_irq_out)
		else $error("setting request longer than one cycle");
	a_snooze_end: assert property (snooze_exit_out |-> measure_end_irq_out)
		else $error("snooze exit without end");
	c_start: cover property (start);
	c_read: cover property (rd_res && wait_rd);
	c_snooze: cover property (snooze_exit_out);
endmodule
bind touch_sensing_control touch_sense_props i_props (.clock_in(clock_in),
	.arst_n_in(arst_n_in), .psel_in(psel_in), .penable_in(penable_in),
	.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
	.pready_out(pready_out), .pslverr_out(pslverr_out),
	.event_trigger_in(event_trigger_in), .snooze_in(snooze_in), .mutual_out(mutual_out),
	.transmit_supply_select_out(transmit_supply_select_out),
	.current_range_out(current_range_out), .measure_supply_on_out(measure_supply_on_out),
	.filter_charge_control_out(filter_charge_control_out),
	.setting_request_irq_out(setting_request_irq_out),
	.result_read_irq_out(result_read_irq_out), .measure_end_irq_out(measure_end_irq_out),
	.snooze_exit_out(snooze_exit_out));
`default_nettype wire

// ===== verification/touch_sensing_control_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "touch_sense_defines.vh"
module touch_sensing_control_test;
	logic clock_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, snooze = 1'b0, fire = 1'b0, slow = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdata, v;
	logic pready, pslverr, slverr, sensor_pulse, event_trigger, measuring, mutual, snz_exit, drive;
	logic drive_q = 1'b0;
	logic [5:0] chan;
	logic [15:0] pin_current;
	logic [9:0] offset;
	logic [1:0] txsel, range;
	logic [2:0] irqs;
	logic [2:0] pwr;
	int err_total = 0, check_count = 0, n, drive_edges = 0;
	always #5 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		drive_q <= drive;
		if (drive && !drive_q)
			drive_edges <= drive_edges + 1;
	end
	touch_sensing_control i_dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .ce_in(1'b1),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.event_trigger_in(event_trigger), .snooze_in(snooze), .sensor_pulse_in(sensor_pulse),
		.pin_current_in(pin_current), .channel_out(chan), .mutual_out(mutual),
		.measuring_out(measuring), .sensor_drive_out(drive), .offset_current_out(offset),
		.transmit_supply_select_out(txsel), .current_range_out(range),
		.measure_supply_on_out(pwr[0]), .filter_charge_control_out(pwr[1]),
		.supply_operating_level_out(pwr[2]), .setting_request_irq_out(irqs[0]),
		.result_read_irq_out(irqs[1]), .measure_end_irq_out(irqs[2]),
		.snooze_exit_out(snz_exit));
	touch_far_side i_far (.clock_in(clock_in), .arst_n_in(arst_n_in), .measuring_in(measuring),
		.fire_in(fire), .slow_in(slow), .sensor_pulse_out(sensor_pulse),
		.event_trigger_out(event_trigger), .pin_current_out(pin_current));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge clock_in);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		do begin
			@(posedge clock_in);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rdata = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) check("pready", 0, 1);
	endtask
	task automatic wait_irq(input int sel, input int max, output int cnt);
		cnt = 0;
		#1;
		while (irqs[sel] !== 1'b1 && cnt < max) begin
			@(posedge clock_in);
			#1;
			cnt++;
		end
		if (irqs[sel] !== 1'b1) cnt = -1;
	endtask
	task automatic one_channel(input logic [5:0] ch, input int div, input int w);
		int c;
		wait_irq(0, 100, c);
		check("setting wait", c, w);
		check("channel out", chan, ch);
		apb(1, `TS_OFS_CHCFG, 32'h0004_0D55);
		#1 check("measuring", measuring, 1);
		wait_irq(1, 400, c);
		// duration 3 gives four operating ticks; the first may come one clock after the write
		check("sense span", c >= 3 * div + 1 && c <= 4 * div, 1);
		check("offset", offset, 10'h155);
		apb(0, `TS_OFS_STATUS, 0);
		check("status", {rdata[14:12], rdata[10:8], rdata[5:0]}, {6'h0B, ch});
		apb(0, `TS_OFS_RESULT, 0);
		check("result channel", rdata[21:16], ch);
	endtask
	task automatic end_wait;
		wait_irq(2, 20, n);
		check("end wait", n, 0);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		report_and_stop;
	end
	initial begin
		repeat (4) @(posedge clock_in);
		arst_n_in <= 1'b1;
		apb(0, `TS_OFS_CTRL_A, 0);
		check("ctrl_a reset", rdata, `TS_CTRL_A_RESET);
		apb(0, 8'h40, 32'h0);
		check("unmapped error", slverr, 1);
		check("unmapped data", rdata, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			v = (i << 6) | (i << 8) | (i[0] << 10) | (i[0] << 11) | (i << 12) | (i << 14) |
				(i[1] << 17);
			apb(1, `TS_OFS_CTRL_A, v);
			@(posedge clock_in);
			#1;
			check("tx supply", txsel, i);
			check("range", range, i);
			check("mutual", mutual, i[1]);
			check("supply on filter level", pwr, {i[0], i[1:0]});
			apb(0, `TS_OFS_CTRL_A, 0);
			check("ctrl_a readback", rdata, v & `TS_CTRL_A_MASK);
		end
		$display("test control fields done");
		for (int cs = 0; cs < 4; cs++) begin
			apb(1, `TS_OFS_CHSEL, cs * 11);
			apb(1, `TS_OFS_CTRL_A, (cs << 12) | 1);
			one_channel(cs * 11, 1 << cs, 0);
			end_wait;
		end
		$display("test single scan done");
		slow <= 1'b1;
		apb(1, `TS_OFS_CHEN_LO, 32'h0000_0004);
		apb(1, `TS_OFS_CHEN_HI, 32'h0000_0008);
		apb(1, `TS_OFS_CTRL_B, 32'h0000_000E);
		apb(1, `TS_OFS_CTRL_A, 32'h0000_4001);
		one_channel(2, 1, 0);
		one_channel(35, 1, 0);
		end_wait;
		$display("test multi scan done");
		apb(1, `TS_OFS_CHSEL, 4);
		apb(1, `TS_OFS_CTRL_A, 32'h0000_0006);
		apb(1, `TS_OFS_CTRL_A, 32'h0000_0007);
		wait_irq(0, 20, n);
		check("software start ignored", n, -1);
		@(posedge clock_in);
		snooze <= 1'b1;
		fire <= 1'b1;
		one_channel(4, 1, 2);
		end_wait;
		check("snooze exit", snz_exit, 1);
		// threshold still zero, so with judgement on every result counts as a touch
		apb(1, `TS_OFS_CTRL_B, 32'h10);
		fire <= 1'b0;
		@(posedge clock_in);
		fire <= 1'b1;
		one_channel(4, 1, 2);
		end_wait;
		check("touch keeps snooze", snz_exit, 0);
		@(posedge clock_in);
		snooze <= 1'b0;
		fire <= 1'b0;
		$display("test event start done");
		apb(1, `TS_OFS_CTRL_A, 32'h0);
		apb(1, `TS_OFS_CTRL_A, 32'h1);
		wait_irq(0, 20, n);
		check("start before init", n, 0);
		apb(0, `TS_OFS_CTRL_A, 0);
		check("busy readback", rdata[0], 1);
		apb(1, `TS_OFS_CTRL_A, 32'h10);
		apb(0, `TS_OFS_STATUS, 0);
		check("status after init", {rdata[12], rdata[10:8]}, 0);
		apb(1, `TS_OFS_CTRL_B, 32'h1);
		apb(1, `TS_OFS_CTRL_A, 32'h1);
		one_channel(4, 1, 0);
		check("current value", rdata[15:0], 16'h1234);
		end_wait;
		check("drive pulses", drive_edges > 0, 1);
		$display("test init and current mode done");
		report_and_stop;
	end
endmodule
`default_nettype wire
